// ### verilog/sga_defs.vh
// Purpose: shared constants of the grouped-carry arithmetic unit
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes:   definitions only
`ifndef SGA_DEFS_VH
`define SGA_DEFS_VH

// register byte offsets
`define SGA_OFF_XCH      12'h000
`define SGA_OFF_ACC      12'h004
`define SGA_OFF_QUO      12'h008
`define SGA_OFF_CMD      12'h00c
`define SGA_OFF_STATUS   12'h010

// reset values
`define SGA_RST_WORD     6'h00
`define SGA_RST_PHASE    2'h0

// adder phase counter states
`define SGA_PH_IDLE      2'h0
`define SGA_PH_ONE       2'h1
`define SGA_PH_TWO       2'h2
`define SGA_PH_THREE     2'h3

// command codes, written to the command register
`define SGA_CMD_NOP      4'h0
`define SGA_CMD_A_TO_X   4'h1
`define SGA_CMD_Q_TO_X   4'h2
`define SGA_CMD_X_TO_A   4'h3
`define SGA_CMD_X_TO_Q   4'h4
`define SGA_CMD_SHR      4'h5
`define SGA_CMD_SHL      4'h6
`define SGA_CMD_ADD      4'h7
`define SGA_CMD_CMP_X    4'h8
`define SGA_CMD_CPY_SGN  4'h9
`define SGA_CMD_CLR_FLG  4'ha

// status register field positions
`define SGA_ST_PHASE_LO  0
`define SGA_ST_PHASE_HI  1
`define SGA_ST_OVF       2
`define SGA_ST_ONES      3
`define SGA_ST_SIGN      4
`define SGA_ST_BUSY      5

// magnitude of all ones (octal 37)
`define SGA_MAG_ONES     5'h1f

`endif

// ### verilog/sga_adder.v
// Purpose: complementing adder network, toggle mask per phase
// Assumes: bit 1 is the most significant magnitude bit, bit 5 the least
// Notes:   purely combinational; the caller applies the mask on one edge
`timescale 1ns/10ps
`include "sga_defs.vh"

module sga_adder (
  // operands, state held before the phase
  input  wire [1:5] acc_mag,
  input  wire [1:5] xch_mag,
  input  wire [1:0] phase,
  // results
  output reg  [1:5] toggle,
  output reg        end_carry,
  output wire       all_ones
);

  // high bit of a group toggles with inner carry folded in
  function hi_toggle;
    input xh;
    input xl;
    input al;
    begin
      hi_toggle = (xh & ~(al & xl)) | (~xh & al & xl);
    end
  endfunction

  // group carry seen from the state after phase 1
  function grp_carry;
    input xl;
    input xh;
    input al;
    input ah;
    begin
      grp_carry = (xl & ~al & (xh | ~ah)) | (xh & ~ah);
    end
  endfunction

  wire g_low;
  wire g_mid;
  wire p_mid;
  wire c_left;

  assign g_low    = grp_carry(xch_mag[5], xch_mag[4], acc_mag[5], acc_mag[4]);
  assign g_mid    = grp_carry(xch_mag[3], xch_mag[2], acc_mag[3], acc_mag[2]);
  assign p_mid    = acc_mag[2] & acc_mag[3];
  assign c_left   = g_mid | (p_mid & g_low);
  assign all_ones = (acc_mag == `SGA_MAG_ONES);

  always @* begin
    toggle    = 5'h00;
    end_carry = 1'b0;
    case (phase)
      `SGA_PH_ONE: begin
        toggle[5] = xch_mag[5];
        toggle[3] = xch_mag[3];
        toggle[1] = xch_mag[1];
        toggle[4] = hi_toggle(xch_mag[4], xch_mag[5], acc_mag[5]);
        toggle[2] = hi_toggle(xch_mag[2], xch_mag[3], acc_mag[3]);
        end_carry = acc_mag[1] & xch_mag[1];
      end
      `SGA_PH_TWO: begin
        // low group carry ripples into the middle group
        toggle[3] = g_low;
        toggle[2] = g_low & acc_mag[3];
        toggle[1] = c_left;
        end_carry = c_left & acc_mag[1];
      end
      default: begin
        toggle    = 5'h00;
        end_carry = 1'b0;
      end
    endcase
  end

endmodule // sga_adder

// ### verilog/sga_arith_unit.v
// Purpose: six-bit sign-magnitude arithmetic section with APB access
// Assumes: a sequencer issues commands over APB; word bit 5 is the sign
// Notes:   bit 0 of each register is the sign and the leftmost bit
//
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps
`include "sga_defs.vh"

// What this block does
// - exchange register six bits, sign plus fraction
// - words reach acc and quo via exchange or a direct APB write
// - exchange holds the second arithmetic operand
// - six-bit accumulator, transfers into exchange
// - accumulator shifts right into quotient, reverse left
// - six-bit quotient, loads via exchange or a direct APB write
// - product formed across the eleven-bit pair
// - quotient sign copied from accumulator sign
// - division uses pair, exchange, quotient, remainder
// - adder toggles accumulator bits in place
// - low group bits toggle when exchange bit set
// - high group bits toggle with inner carry
// - group carry evaluated in phase two
// - middle propagate enable is bits two and three
// - middle carry out modifies bit one
// - end carry in phase one or two
// - all-ones sum sensed only in phase three
// - overflow captures end carry, all-ones flag
// - phase counter steps one two three, then zero
// - sign flag set when signs differ
module sga_arith_unit #(
  parameter AW = 12
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // sequencing freeze towards the main control
  output reg           adder_busy
);

  // architectural registers, index 0 is the sign
  reg  [0:5] xch;
  reg  [0:5] acc;
  reg  [0:5] quo;
  reg  [1:0] phase;
  reg        overflow_flag;
  reg        all_ones_flag;
  reg        sign_flag;

  // next values
  reg  [0:5] next_xch;
  reg  [0:5] next_acc;
  reg  [0:5] next_quo;
  reg  [1:0] next_phase;
  reg        next_ovf;
  reg        next_ones;
  reg        next_ovf_set;
  reg        next_ones_set;
  reg        next_flag_clr;
  reg        next_sign;
  reg        next_busy;

  // next read values
  reg  [31:0] next_prdata;
  reg         next_pslverr;

  // adder network
  wire [1:5] toggle;
  wire       end_carry;
  wire       mag_all_ones;

  // bus decode
  wire       wr_access;
  wire       rd_setup;
  wire [3:0] cmd;
  wire       idle;

  function mapped;
    input [AW-1:0] addr;
    begin
      mapped = (addr == `SGA_OFF_XCH) || (addr == `SGA_OFF_ACC) ||
               (addr == `SGA_OFF_QUO) || (addr == `SGA_OFF_CMD) ||
               (addr == `SGA_OFF_STATUS);
    end
  endfunction

  function is_reg;
    input [AW-1:0] addr;
    input [11:0]   off;
    begin
      is_reg = (addr == off);
    end
  endfunction

  // status word assembled in one place for the read path
  function [31:0] status_word;
    input [1:0] ph;
    input       ovf;
    input       ones;
    input       sgn;
    input       busy;
    begin
      status_word                                     = 32'h00000000;
      status_word[`SGA_ST_PHASE_HI:`SGA_ST_PHASE_LO] = ph;
      status_word[`SGA_ST_OVF]                        = ovf;
      status_word[`SGA_ST_ONES]                       = ones;
      status_word[`SGA_ST_SIGN]                       = sgn;
      status_word[`SGA_ST_BUSY]                       = busy;
    end
  endfunction

  sga_adder u_adder (
    .acc_mag   (acc[1:5]),
    .xch_mag   (xch[1:5]),
    .phase     (phase),
    .toggle    (toggle),
    .end_carry (end_carry),
    .all_ones  (mag_all_ones)
  );

  // pready is high from the first edge after reset, so the access phase is the write edge
  assign wr_access = psel & penable & pwrite;
  assign rd_setup  = psel & ~penable;
  assign cmd       = pwdata[3:0];
  assign idle      = (phase == `SGA_PH_IDLE);

  always @* begin
    next_xch      = xch;
    next_acc      = acc;
    next_quo      = quo;
    next_phase    = phase;
    next_ovf_set  = 1'b0;
    next_ones_set = 1'b0;
    next_flag_clr = 1'b0;
    next_ovf      = overflow_flag;
    case (phase)
      `SGA_PH_IDLE: begin
        // software writes only land while the adder is idle
        if (wr_access && is_reg(paddr, `SGA_OFF_XCH)) begin
          next_xch = pwdata[5:0];
        end
        if (wr_access && is_reg(paddr, `SGA_OFF_ACC)) begin
          next_acc = pwdata[5:0];
        end
        if (wr_access && is_reg(paddr, `SGA_OFF_QUO)) begin
          next_quo = pwdata[5:0];
        end
        if (wr_access && is_reg(paddr, `SGA_OFF_CMD)) begin
          case (cmd)
            `SGA_CMD_A_TO_X: begin
              next_xch = acc;
            end
            `SGA_CMD_Q_TO_X: begin
              next_xch = quo;
            end
            `SGA_CMD_X_TO_A: begin
              next_acc = xch;
            end
            `SGA_CMD_X_TO_Q: begin
              next_quo = xch;
            end
            `SGA_CMD_SHR: begin
              // overflow feeds bit 1, bit 5 of acc feeds quotient
              next_acc[1:5] = {overflow_flag, acc[1:4]};
              next_quo[1:5] = {acc[5], quo[1:4]};
            end
            `SGA_CMD_SHL: begin
              // bit 1 leaves into the overflow flag
              next_ovf      = acc[1];
              next_acc[1:5] = {acc[2:5], quo[1]};
              next_quo[1:5] = {quo[2:5], 1'b0};
            end
            `SGA_CMD_ADD: begin
              next_phase = `SGA_PH_ONE;
            end
            `SGA_CMD_CMP_X: begin
              // subtraction and mixed-sign add use the complement
              next_xch[1:5] = ~xch[1:5];
            end
            `SGA_CMD_CPY_SGN: begin
              next_quo[0] = acc[0];
            end
            `SGA_CMD_CLR_FLG: begin
              next_flag_clr = 1'b1;
            end
            default: begin
              next_phase = phase;
            end
          endcase
        end
      end
      `SGA_PH_ONE: begin
        next_acc[1:5] = acc[1:5] ^ toggle;
        next_ovf_set  = end_carry;
        next_phase    = `SGA_PH_TWO;
      end
      `SGA_PH_TWO: begin
        next_acc[1:5] = acc[1:5] ^ toggle;
        next_ovf_set  = end_carry;
        next_phase    = `SGA_PH_THREE;
      end
      `SGA_PH_THREE: begin
        next_ones_set = mag_all_ones;
        next_phase    = `SGA_PH_IDLE;
      end
      default: begin
        next_phase = `SGA_PH_IDLE;
      end
    endcase
    // a set always wins over a clear in the same cycle
    next_ovf  = (next_ovf & ~next_flag_clr) | next_ovf_set;
    next_ones = (all_ones_flag & ~next_flag_clr) | next_ones_set;
    // sign flag tracks the registers as they will stand after this edge
    next_sign = next_acc[0] ^ next_xch[0];
    next_busy = (next_phase != `SGA_PH_IDLE);
  end

  // exchange register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xch <= `SGA_RST_WORD;
    end else begin
      xch <= next_xch;
    end
  end

  // accumulator, updated in place by the adder phases
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= `SGA_RST_WORD;
    end else begin
      acc <= next_acc;
    end
  end

  // quotient register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quo <= `SGA_RST_WORD;
    end else begin
      quo <= next_quo;
    end
  end

  // adder phase counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= `SGA_RST_PHASE;
    end else begin
      phase <= next_phase;
    end
  end

  // overflow flag, sticky until cleared or loaded by a left shift
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= next_ovf;
    end
  end

  // all-ones flag, sticky until cleared
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      all_ones_flag <= 1'b0;
    end else begin
      all_ones_flag <= next_ones;
    end
  end

  // sign flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sign_flag <= 1'b0;
    end else begin
      sign_flag <= next_sign;
    end
  end

  // freeze towards the main control while phases run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adder_busy <= 1'b0;
    end else begin
      adder_busy <= next_busy;
    end
  end

  // read data picked in setup so it stands through the access phase
  always @* begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (rd_setup) begin
      next_pslverr = ~mapped(paddr);
      next_prdata  = 32'h00000000;
      if (!pwrite) begin
        if (is_reg(paddr, `SGA_OFF_XCH)) begin
          next_prdata = {26'h0000000, xch};
        end
        if (is_reg(paddr, `SGA_OFF_ACC)) begin
          next_prdata = {26'h0000000, acc};
        end
        if (is_reg(paddr, `SGA_OFF_QUO)) begin
          next_prdata = {26'h0000000, quo};
        end
        if (is_reg(paddr, `SGA_OFF_STATUS)) begin
          next_prdata = status_word(phase, overflow_flag, all_ones_flag,
                                    sign_flag, adder_busy);
        end
      end
    end
  end

  // read data register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // no wait states: every access phase is answered at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // error response for holes in the map
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

endmodule // sga_arith_unit

// ### bench/sga_arith_unit_asserts.sv
// Purpose: port-level checks of the arithmetic unit
// Assumes: every access phase is answered at once
// Notes:   bound to the unit at the foot
`timescale 1ns/10ps
`include "sga_defs.vh"
module sga_chk #(
  parameter AW = 12
) (
  // clock and reset
  input wire          pclk,
  input wire          presetn,
  // apb
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0]   pwdata,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  // freeze
  input wire          adder_busy
);
  wire acc = psel && penable;
  wire map = paddr <= `SGA_OFF_STATUS && paddr[1:0] == 2'h0;
  wire go  = acc && pwrite && paddr == `SGA_OFF_CMD && pwdata[3:0] == `SGA_CMD_ADD;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_START: assert property (go && !adder_busy |=> adder_busy)
    else $error("add did not start");
  AST_LEN: assert property ($rose(adder_busy) |-> adder_busy[*3] ##1 !adder_busy)
    else $error("adder phases not three");
  AST_IDLE: assert property (!adder_busy && !go |=> !adder_busy)
    else $error("adder started by itself");
  AST_READY: assert property (acc |-> pready)
    else $error("access not answered");
  AST_ERR: assert property (acc && !map |-> pslverr)
    else $error("unmapped access not refused");
  AST_NOERR: assert property (acc && map |-> !pslverr)
    else $error("mapped access refused");
  AST_UPPER: assert property (acc && !pwrite |-> prdata[31:6] == 26'h0)
    else $error("read word wider than six bits");
  AST_ZERO: assert property (acc && !pwrite && (!map || paddr == `SGA_OFF_CMD) |-> prdata == 0)
    else $error("command or hole read not zero");
endmodule // sga_chk

bind sga_arith_unit sga_chk #(.AW(AW)) sga_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .adder_busy(adder_busy));

// ### bench/sga_seq_model.sv
// Purpose: main sequencer model, apb master
// Assumes: one transfer at a time
// Notes:   idle write data shows the inverse of the last word
`timescale 1ns/10ps
module sga_seq (
  // clock
  input wire         pclk,
  // apb master
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  input wire  [31:0] prdata,
  input wire         pready,
  input wire         pslverr
);
  reg [31:0] rdata;
  reg        rerr;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 0;
  end
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d;
    end
  endtask
endmodule // sga_seq

// ### bench/tb.sv
// Purpose: directed bench of the arithmetic unit
// Assumes: sequencer model drives the apb side
// Notes:   flags are cleared before each add
`timescale 1ns/10ps
`include "sga_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
`define RD sga_seq_i.rdata
module tb;
  reg         pclk;
  reg         presetn;
  wire        psel, penable, pwrite, pready, pslverr, busy;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  int         bad_count = 0;
  int         compares = 0;
  int         cyc = 0;
  sga_arith_unit sga_arith_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adder_busy(busy));
  sga_seq sga_seq_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test;
    end
  end
  task finish_test;
    begin
      $display("compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task wr(input [11:0] a, input [5:0] d);
    sga_seq_i.xfer(1'b1, a, {26'h0, d});
  endtask
  task cmd(input [3:0] c);
    sga_seq_i.xfer(1'b1, `SGA_OFF_CMD, {28'h0, c});
  endtask
  task rd(input [11:0] a);
    sga_seq_i.xfer(1'b0, a, 32'h0);
  endtask
  task t_bus;
    begin
      rd(`SGA_OFF_ACC);
      `CHK(`RD[5:0], 6'h00)
      rd(12'h014);
      `CHK(sga_seq_i.rerr, 1'b1)
      `CHK(`RD, 32'h0)
      rd(`SGA_OFF_CMD);
      `CHK(`RD, 32'h0)
      wr(`SGA_OFF_STATUS, 6'h3f);
      rd(`SGA_OFF_STATUS);
      `CHK(`RD[5:0], 6'h00)
      $display("done bus");
    end
  endtask
  task t_move;
    begin
      wr(`SGA_OFF_XCH, 6'h2a);
      cmd(`SGA_CMD_X_TO_A);
      cmd(`SGA_CMD_X_TO_Q);
      rd(`SGA_OFF_ACC);
      `CHK(`RD[5:0], 6'h2a)
      rd(`SGA_OFF_QUO);
      `CHK(`RD[5:0], 6'h2a)
      wr(`SGA_OFF_ACC, 6'h15);
      cmd(`SGA_CMD_A_TO_X);
      rd(`SGA_OFF_XCH);
      `CHK(`RD[5:0], 6'h15)
      cmd(`SGA_CMD_Q_TO_X);
      rd(`SGA_OFF_XCH);
      `CHK(`RD[5:0], 6'h2a)
      $display("done move");
    end
  endtask
  task t_shift;
    begin
      wr(`SGA_OFF_ACC, 6'h31);
      wr(`SGA_OFF_QUO, 6'h03);
      cmd(`SGA_CMD_CLR_FLG);
      cmd(`SGA_CMD_SHL);
      rd(`SGA_OFF_ACC);
      `CHK(`RD[5:0], 6'h22)
      rd(`SGA_OFF_QUO);
      `CHK(`RD[5:0], 6'h06)
      rd(`SGA_OFF_STATUS);
      `CHK(`RD[2], 1'b1)
      cmd(`SGA_CMD_SHR);
      rd(`SGA_OFF_ACC);
      `CHK(`RD[5:0], 6'h31)
      rd(`SGA_OFF_QUO);
      `CHK(`RD[5:0], 6'h03)
      cmd(`SGA_CMD_CPY_SGN);
      rd(`SGA_OFF_QUO);
      `CHK(`RD[5:0], 6'h23)
      wr(`SGA_OFF_XCH, 6'h05);
      cmd(`SGA_CMD_CMP_X);
      rd(`SGA_OFF_XCH);
      `CHK(`RD[5:0], 6'h1a)
      $display("done shift");
    end
  endtask
  task t_add(input [5:0] a, input [5:0] x);
    reg [5:0] s;
    begin
      s = a[4:0] + x[4:0];
      wr(`SGA_OFF_ACC, a);
      wr(`SGA_OFF_XCH, x);
      cmd(`SGA_CMD_CLR_FLG);
      cmd(`SGA_CMD_ADD);
      rd(`SGA_OFF_STATUS);
      while (`RD[5] !== 1'b0) rd(`SGA_OFF_STATUS);
      `CHK(`RD[2], s[5])
      `CHK(`RD[3], s[4:0] == 5'h1f)
      `CHK(`RD[4], a[5] ^ x[5])
      rd(`SGA_OFF_ACC);
      `CHK(`RD[5:0], {a[5], s[4:0]})
    end
  endtask
  task t_adds;
    begin
      t_add(6'h01, 6'h01);
      t_add(6'h06, 6'h03);
      t_add(6'h03, 6'h01);
      t_add(6'h0f, 6'h21);
      t_add(6'h08, 6'h08);
      t_add(6'h3f, 6'h01);
      t_add(6'h10, 6'h30);
      t_add(6'h15, 6'h0a);
      $display("done add");
    end
  endtask
  initial begin
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_bus;
    t_move;
    t_shift;
    t_adds;
    finish_test;
  end
endmodule // tb
